// File: verilog/wtpb_pkg.sv
package wtpb_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 16;
    localparam int unsigned IDX_W = 10;
    localparam logic [IDX_W-1:0] IDX_WORD_USE = 10'h101;
    localparam logic [IDX_W-1:0] IDX_TOTAL = 10'h102;
    localparam logic [IDX_W-1:0] IDX_START = 10'h103;
    localparam logic [IDX_W-1:0] IDX_PER_FRAME = 10'h105;
    localparam logic [IDX_W-1:0] IDX_STARTUP = 10'h107;
    localparam logic [IDX_W-1:0] IDX_DCHECK = 10'h108;
    localparam logic [IDX_W-1:0] IDX_CONTROL = 10'h110;
    localparam logic [IDX_W-1:0] IDX_ERROR = 10'h111;
    localparam logic [IDX_W-1:0] IDX_STATUS = 10'h112;
    localparam logic [IDX_W-1:0] IDX_ACT_USE = 10'h311;
    localparam logic [IDX_W-1:0] IDX_ACT_TOTAL = 10'h312;
    localparam logic [IDX_W-1:0] IDX_ACT_START = 10'h313;
    localparam logic [IDX_W-1:0] IDX_ACT_PER_FRAME = 10'h314;
    localparam logic [IDX_W-1:0] IDX_ACT_STARTUP = 10'h315;
    localparam logic [IDX_W-1:0] IDX_ACT_DCHECK = 10'h316;
    localparam logic [REG_W-1:0] RST_WORD_USE = 16'h0000;
    localparam logic [REG_W-1:0] RST_TOTAL = 16'h0000;
    localparam logic [REG_W-1:0] RST_START = 16'h0000;
    localparam logic [REG_W-1:0] RST_PER_FRAME = 16'h0000;
    localparam logic [REG_W-1:0] RST_STARTUP = 16'h0000;
    localparam logic [REG_W-1:0] RST_DCHECK = 16'h0000;
    localparam logic [REG_W-1:0] CODE_NONE = 16'h0000;
    localparam logic [REG_W-1:0] USE_OFF = 16'h0000;
    localparam logic [REG_W-1:0] USE_ON = 16'h0001;
    localparam logic [REG_W-1:0] MAX_USE = 16'h0001;
    localparam logic [REG_W-1:0] MAX_TOTAL = 16'h000A;
    localparam logic [REG_W-1:0] MAX_START = 16'h01FF;
    localparam logic [REG_W-1:0] MAX_PER_FRAME = 16'h0005;
    localparam logic [REG_W-1:0] MAX_STARTUP = 16'h0001;
    localparam logic [REG_W-1:0] MAX_DCHECK = 16'h0020;
    localparam logic [REG_W-1:0] ERR_NONE = 16'h0000;
    localparam logic [REG_W-1:0] ERR_USE = 16'h1802;
    localparam logic [REG_W-1:0] ERR_TOTAL = 16'h1803;
    localparam logic [REG_W-1:0] ERR_START = 16'h1804;
    localparam logic [REG_W-1:0] ERR_PER_FRAME = 16'h1805;
    localparam logic [REG_W-1:0] ERR_STARTUP = 16'h1806;
    localparam logic [REG_W-1:0] ERR_DCHECK = 16'h1807;
    localparam logic [REG_W-1:0] ERR_COMBO = 16'h180D;
    localparam int unsigned CTRL_APPLY_BIT = 0;
    localparam int unsigned STAT_ERR_BIT = 0;
    localparam int unsigned STAT_DONE_BIT = 1;
    localparam logic [DATA_W-1:0] UNMAPPED_DATA = 32'h0000_0000;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CHECK,
        ST_COMMIT
    } wtpb_state_t;
endpackage

// File: verilog/wtpb_range_check.sv
`timescale 1ns/1ns
module wtpb_range_check #(
    parameter logic [15:0] MAX_CODE = 16'h0000
) (
    input wire logic [15:0] value,
    output logic ok
);
    // upper bound only; every code starts at zero
    assign ok = (value <= MAX_CODE);
endmodule

// File: verilog/wtpb_bank.sv
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ns
// How it works
// - total points: 0 off, 1..A twice-doubling words
// - bad total code reports 1803H
// - erroneous setting keeps its committed copy
// - bad word combination reports 180DH
// - start address 0..511, resets zero, used
// - start address beyond 511 reports 1804H
// - per-frame: 0 off, 1..5 words
// - per-frame above total is a combination fault
// - bad per-frame code reports 1805H
// - startup mode 0 plain, 1 acquire slaves
// - bad startup code reports 1806H
// - double check 0 bitwise, 1..1F, 20H
// - double check above 20H reports 1807H
// - word use register off or on
// - word field combinations checked; with use on, a total above A blocks only itself
module wtpb_bank (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [wtpb_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [wtpb_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [wtpb_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [wtpb_pkg::REG_W-1:0] active_word_use,
    output logic [wtpb_pkg::REG_W-1:0] active_total_points,
    output logic [wtpb_pkg::REG_W-1:0] active_start_address,
    output logic [wtpb_pkg::REG_W-1:0] active_points_per_frame,
    output logic [wtpb_pkg::REG_W-1:0] active_startup_mode,
    output logic [wtpb_pkg::REG_W-1:0] active_double_check_mode,
    output logic [wtpb_pkg::REG_W-1:0] error_code,
    output logic param_error,
    output logic apply_done
);
    import wtpb_pkg::*;

    logic [REG_W-1:0] word_use;
    logic [REG_W-1:0] word_total_points;
    logic [REG_W-1:0] word_start_address;
    logic [REG_W-1:0] word_points_per_frame;
    logic [REG_W-1:0] startup_mode;
    logic [REG_W-1:0] double_check_mode;
    logic param_apply_request_flag;
    logic apply_prev;
    logic apply_rise;
    logic [REG_W-1:0] snap_use;
    logic [REG_W-1:0] snap_total;
    logic [REG_W-1:0] snap_start;
    logic [REG_W-1:0] snap_pf;
    logic [REG_W-1:0] snap_startup;
    logic [REG_W-1:0] snap_dcheck;
    logic ok_use;
    logic ok_total;
    logic ok_start;
    logic ok_pf;
    logic ok_startup;
    logic ok_dcheck;
    logic combo_ok;
    logic bad_use;
    logic bad_total;
    logic bad_start;
    logic bad_pf;
    logic bad_startup;
    logic bad_dcheck;
    logic bad_combo;
    logic [REG_W-1:0] next_error;
    wtpb_state_t state;
    wtpb_state_t next_state;
    logic [IDX_W-1:0] idx;
    logic req;
    logic wr_fire;
    logic [DATA_W-1:0] next_readdata;
    logic stat_clear_err;
    logic stat_clear_done;
    logic err_set;
    logic apply_done_sticky;
    function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old,
        input logic [DATA_W-1:0] wdata, input logic [3:0] be);
        logic [REG_W-1:0] res;
        res = old;
        if (be[0]) res[7:0] = wdata[7:0];
        if (be[1]) res[15:8] = wdata[15:8];
        return res;
    endfunction

    // bus side: one wait cycle, then the access lands
    assign idx = avs_address[ADDR_W-1:2];
    assign req = avs_read | avs_write;
    assign wr_fire = avs_write & ~avs_waitrequest;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            avs_waitrequest <= 1'b1;
        end else if (req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_comb begin
        next_readdata = UNMAPPED_DATA;
        case (idx)
            IDX_WORD_USE: next_readdata[REG_W-1:0] = word_use;
            IDX_TOTAL: next_readdata[REG_W-1:0] = word_total_points;
            IDX_START: next_readdata[REG_W-1:0] = word_start_address;
            IDX_PER_FRAME: next_readdata[REG_W-1:0] = word_points_per_frame;
            IDX_STARTUP: next_readdata[REG_W-1:0] = startup_mode;
            IDX_DCHECK: next_readdata[REG_W-1:0] = double_check_mode;
            IDX_CONTROL: next_readdata[CTRL_APPLY_BIT] = param_apply_request_flag;
            IDX_ERROR: next_readdata[REG_W-1:0] = error_code;
            IDX_STATUS: begin
                next_readdata[STAT_ERR_BIT] = param_error;
                next_readdata[STAT_DONE_BIT] = apply_done_sticky;
            end
            IDX_ACT_USE: next_readdata[REG_W-1:0] = active_word_use;
            IDX_ACT_TOTAL: next_readdata[REG_W-1:0] = active_total_points;
            IDX_ACT_START: next_readdata[REG_W-1:0] = active_start_address;
            IDX_ACT_PER_FRAME: next_readdata[REG_W-1:0] = active_points_per_frame;
            IDX_ACT_STARTUP: next_readdata[REG_W-1:0] = active_startup_mode;
            IDX_ACT_DCHECK: next_readdata[REG_W-1:0] = active_double_check_mode;
            default: next_readdata = UNMAPPED_DATA;
        endcase
    end

    // data is loaded as waitrequest drops, so it stands at the taking edge
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            avs_readdata <= UNMAPPED_DATA;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= next_readdata;
        end
    end

    // raw writes only store; nothing is checked here
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            word_use <= RST_WORD_USE;
            word_total_points <= RST_TOTAL;
            word_start_address <= RST_START;
            word_points_per_frame <= RST_PER_FRAME;
            startup_mode <= RST_STARTUP;
            double_check_mode <= RST_DCHECK;
        end else if (wr_fire) begin
            case (idx)
                IDX_WORD_USE: word_use <= merge16(word_use, avs_writedata, avs_byteenable);
                IDX_TOTAL: begin
                    word_total_points <= merge16(word_total_points, avs_writedata,
                        avs_byteenable);
                end
                IDX_START: begin
                    word_start_address <= merge16(word_start_address, avs_writedata,
                        avs_byteenable);
                end
                IDX_PER_FRAME: begin
                    word_points_per_frame <= merge16(word_points_per_frame, avs_writedata,
                        avs_byteenable);
                end
                IDX_STARTUP: startup_mode <= merge16(startup_mode, avs_writedata, avs_byteenable);
                IDX_DCHECK: begin
                    double_check_mode <= merge16(double_check_mode, avs_writedata,
                        avs_byteenable);
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            param_apply_request_flag <= 1'b0;
        end else if (wr_fire && idx == IDX_CONTROL && avs_byteenable[0]) begin
            param_apply_request_flag <= avs_writedata[CTRL_APPLY_BIT];
        end
    end

    // host must drop the flag and raise it again for a new apply
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            apply_prev <= 1'b0;
        end else begin
            apply_prev <= param_apply_request_flag;
        end
    end

    assign apply_rise = param_apply_request_flag & ~apply_prev;

    // snapshot so that writes during the check cannot tear it
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            snap_use <= RST_WORD_USE;
            snap_total <= RST_TOTAL;
            snap_start <= RST_START;
            snap_pf <= RST_PER_FRAME;
            snap_startup <= RST_STARTUP;
            snap_dcheck <= RST_DCHECK;
        end else if (state == ST_IDLE && apply_rise) begin
            snap_use <= word_use;
            snap_total <= word_total_points;
            snap_start <= word_start_address;
            snap_pf <= word_points_per_frame;
            snap_startup <= startup_mode;
            snap_dcheck <= double_check_mode;
        end
    end

    wtpb_range_check #(.MAX_CODE(MAX_USE)) u_chk_use (
        .value(snap_use), .ok(ok_use));
    wtpb_range_check #(.MAX_CODE(MAX_TOTAL)) u_chk_total (
        .value(snap_total), .ok(ok_total));
    wtpb_range_check #(.MAX_CODE(MAX_START)) u_chk_start (
        .value(snap_start), .ok(ok_start));
    wtpb_range_check #(.MAX_CODE(MAX_PER_FRAME)) u_chk_pf (
        .value(snap_pf), .ok(ok_pf));
    wtpb_range_check #(.MAX_CODE(MAX_STARTUP)) u_chk_startup (
        .value(snap_startup), .ok(ok_startup));
    wtpb_range_check #(.MAX_CODE(MAX_DCHECK)) u_chk_dcheck (
        .value(snap_dcheck), .ok(ok_dcheck));

    // codes compare directly: each step doubles the word count
    always_comb begin
        combo_ok = 1'b0;
        if (snap_use == USE_OFF) begin
            combo_ok = (snap_total == CODE_NONE) && (snap_start == CODE_NONE)
                && (snap_pf == CODE_NONE);
        end else if (snap_use == USE_ON) begin
            combo_ok = (snap_total != CODE_NONE) && (snap_pf != CODE_NONE)
                && (snap_pf <= snap_total) && (snap_pf <= MAX_PER_FRAME)
                && (snap_start <= MAX_START);
        end
    end

    // lowest code wins when several faults coexist
    always_comb begin
        if (!ok_use) begin
            next_error = ERR_USE;
        end else if (!ok_total) begin
            next_error = ERR_TOTAL;
        end else if (!ok_start) begin
            next_error = ERR_START;
        end else if (!ok_pf) begin
            next_error = ERR_PER_FRAME;
        end else if (!ok_startup) begin
            next_error = ERR_STARTUP;
        end else if (!ok_dcheck) begin
            next_error = ERR_DCHECK;
        end else if (!combo_ok) begin
            next_error = ERR_COMBO;
        end else begin
            next_error = ERR_NONE;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (apply_rise) begin
                    next_state = ST_CHECK;
                end
            end
            ST_CHECK: next_state = ST_COMMIT;
            ST_COMMIT: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bad_use <= 1'b0;
            bad_total <= 1'b0;
            bad_start <= 1'b0;
            bad_pf <= 1'b0;
            bad_startup <= 1'b0;
            bad_dcheck <= 1'b0;
            bad_combo <= 1'b0;
            error_code <= ERR_NONE;
        end else if (state == ST_CHECK) begin
            bad_use <= ~ok_use;
            bad_total <= ~ok_total;
            bad_start <= ~ok_start;
            bad_pf <= ~ok_pf;
            bad_startup <= ~ok_startup;
            bad_dcheck <= ~ok_dcheck;
            bad_combo <= ~combo_ok;
            error_code <= next_error;
        end
    end

    // a combination fault blocks every word field, not just one
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            active_word_use <= RST_WORD_USE;
            active_total_points <= RST_TOTAL;
            active_start_address <= RST_START;
            active_points_per_frame <= RST_PER_FRAME;
            active_startup_mode <= RST_STARTUP;
            active_double_check_mode <= RST_DCHECK;
        end else if (state == ST_COMMIT) begin
            if (!bad_use && !bad_combo) begin
                active_word_use <= snap_use;
            end
            if (!bad_total && !bad_combo) begin
                active_total_points <= snap_total;
            end
            if (!bad_start && !bad_combo) begin
                active_start_address <= snap_start;
            end
            if (!bad_pf && !bad_combo) begin
                active_points_per_frame <= snap_pf;
            end
            if (!bad_startup) begin
                active_startup_mode <= snap_startup;
            end
            if (!bad_dcheck) begin
                active_double_check_mode <= snap_dcheck;
            end
        end
    end

    assign err_set = (state == ST_COMMIT) && (error_code != ERR_NONE);
    assign stat_clear_err = wr_fire && idx == IDX_STATUS && avs_byteenable[0]
        && avs_writedata[STAT_ERR_BIT];
    assign stat_clear_done = wr_fire && idx == IDX_STATUS && avs_byteenable[0]
        && avs_writedata[STAT_DONE_BIT];

    // set beats a clear landing in the same cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            param_error <= 1'b0;
        end else if (err_set) begin
            param_error <= 1'b1;
        end else if (stat_clear_err) begin
            param_error <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            apply_done_sticky <= 1'b0;
        end else if (state == ST_COMMIT) begin
            apply_done_sticky <= 1'b1;
        end else if (stat_clear_done) begin
            apply_done_sticky <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            apply_done <= 1'b0;
        end else begin
            apply_done <= (state == ST_COMMIT);
        end
    end
endmodule

// File: sim/wtpb_host.sv
`timescale 1ns/1ns
module wtpb_host (
    input wire logic clock,
    input wire logic avs_waitrequest,
    input wire logic [wtpb_pkg::DATA_W-1:0] avs_readdata,
    output logic [wtpb_pkg::ADDR_W-1:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [wtpb_pkg::DATA_W-1:0] avs_writedata,
    output logic [3:0] avs_byteenable
);
    import wtpb_pkg::*;
    initial begin
        avs_address = 12'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h5A5A_A5A5;
        avs_byteenable = 4'hF;
    end
    // one access, held until waitrequest is seen low at an edge
    task automatic xfer(input logic [IDX_W-1:0] idx, input logic rnw,
                        input logic [15:0] d, output logic [31:0] q);
        @(posedge clock);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {16'h0000, d};
        avs_read <= rnw;
        avs_write <= !rnw;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // released data must not look like the last value
        avs_writedata <= ~{16'h0000, d};
    endtask
endmodule

// File: sim/wtpb_bank_properties.sv
`timescale 1ns/1ns
module wtpb_bank_properties (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [wtpb_pkg::REG_W-1:0] active_word_use,
    input wire logic [wtpb_pkg::REG_W-1:0] active_total_points,
    input wire logic [wtpb_pkg::REG_W-1:0] active_start_address,
    input wire logic [wtpb_pkg::REG_W-1:0] active_points_per_frame,
    input wire logic [wtpb_pkg::REG_W-1:0] active_startup_mode,
    input wire logic [wtpb_pkg::REG_W-1:0] active_double_check_mode,
    input wire logic [wtpb_pkg::REG_W-1:0] error_code,
    input wire logic param_error,
    input wire logic apply_done
);
    import wtpb_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    AST_WAIT_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("no answer");
    AST_WAIT_SHORT: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait low too long");
    AST_WAIT_IDLE: assert property (!avs_waitrequest |-> avs_read || avs_write)
        else $error("stray answer");
    AST_DONE_PULSE: assert property (apply_done |=> !apply_done)
        else $error("done not a pulse");
    AST_COMMIT_APPLY: assert property ($changed({active_word_use, active_total_points,
        active_start_address, active_points_per_frame}) |-> ##[0:1] apply_done)
        else $error("commit without apply");
    AST_ERR_STICKY: assert property (apply_done && error_code != ERR_NONE |-> param_error)
        else $error("error flag missing");
    AST_TOTAL_RANGE: assert property (active_total_points <= MAX_TOTAL)
        else $error("total out of range");
    AST_START_RANGE: assert property (active_start_address <= MAX_START)
        else $error("start out of range");
    AST_PF_RANGE: assert property (active_points_per_frame <= MAX_PER_FRAME)
        else $error("per-frame out of range");
    AST_SU_RANGE: assert property (active_startup_mode <= MAX_STARTUP)
        else $error("startup out of range");
    AST_DC_RANGE: assert property (active_double_check_mode <= MAX_DCHECK)
        else $error("dcheck out of range");
    AST_OFF_ZERO: assert property (active_word_use == USE_OFF |->
        active_total_points == 16'h0000 && active_start_address == 16'h0000
        && active_points_per_frame == 16'h0000) else $error("off with fields");
    AST_PF_LE_TOTAL: assert property (active_word_use == USE_ON |->
        active_points_per_frame != 16'h0000
        && active_points_per_frame <= active_total_points) else $error("per-frame above total");
    cover property (apply_done && error_code == ERR_NONE);
    cover property (apply_done && error_code == ERR_COMBO);
    cover property (!avs_waitrequest && avs_read);
endmodule
bind wtpb_bank wtpb_bank_properties i_props(.clock(clock), .arst_n(arst_n),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .active_word_use(active_word_use), .active_total_points(active_total_points),
    .active_start_address(active_start_address),
    .active_points_per_frame(active_points_per_frame),
    .active_startup_mode(active_startup_mode),
    .active_double_check_mode(active_double_check_mode),
    .error_code(error_code), .param_error(param_error), .apply_done(apply_done));

// File: sim/word_transfer_param_bank_test.sv
`timescale 1ns/1ns
module word_transfer_param_bank_test;
    import wtpb_pkg::*;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [ADDR_W-1:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest, param_error, apply_done;
    logic [DATA_W-1:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [REG_W-1:0] a_use, a_tot, a_st, a_pf, a_su, a_dc, error_code;
    logic [15:0] k;
    logic [15:0] dcv [4] = '{16'h0000, 16'h0001, 16'h001F, 16'h0020};
    int error_cnt = 0;
    int checks = 0;
    always #25 clock = ~clock;
    wtpb_bank i_dut(.clock(clock), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .active_word_use(a_use),
        .active_total_points(a_tot), .active_start_address(a_st),
        .active_points_per_frame(a_pf), .active_startup_mode(a_su),
        .active_double_check_mode(a_dc), .error_code(error_code),
        .param_error(param_error), .apply_done(apply_done));
    wtpb_host i_host(.clock(clock), .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [IDX_W-1:0] idx, input logic [15:0] d);
        logic [31:0] q;
        i_host.xfer(idx, 1'b0, d, q);
    endtask
    task rdchk(input logic [IDX_W-1:0] idx, input logic [15:0] e);
        logic [31:0] q;
        i_host.xfer(idx, 1'b1, 16'h0000, q);
        chk(q, {16'h0000, e});
    endtask
    // write all settings, toggle the apply flag 0 then 1, wait for the result
    task cfg(input logic [15:0] u, t, s, p, m, d, e);
        int n;
        wr(IDX_WORD_USE, u);
        wr(IDX_TOTAL, t);
        wr(IDX_START, s);
        wr(IDX_PER_FRAME, p);
        wr(IDX_STARTUP, m);
        wr(IDX_DCHECK, d);
        wr(IDX_CONTROL, 16'h0000);
        wr(IDX_CONTROL, 16'h0001);
        n = 0;
        while (apply_done !== 1'b1 && n < 20) begin
            @(posedge clock);
            n++;
        end
        if (n == 20) error_cnt++;
        chk(apply_done, 1'b1);
        chk(error_code, e);
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        // generous: whole sequence needs well under 2000 cycles
        repeat (20000) @(posedge clock);
        error_cnt++;
        print_verdict;
    end
    initial begin
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        rdchk(IDX_WORD_USE, 16'h0000);
        rdchk(IDX_TOTAL, 16'h0000);
        rdchk(IDX_START, 16'h0000);
        rdchk(IDX_PER_FRAME, 16'h0000);
        rdchk(IDX_STARTUP, 16'h0000);
        rdchk(IDX_DCHECK, 16'h0000);
        rdchk(10'h104, 16'h0000);
        wr(IDX_WORD_USE, USE_ON);
        wr(IDX_TOTAL, 16'h000A);
        wr(IDX_PER_FRAME, 16'h0001);
        @(posedge clock);
        chk(a_tot, 16'h0000);
        cfg(16'h0001, 16'h000A, 16'h01FF, 16'h0005, 16'h0001, 16'h0020, ERR_NONE);
        rdchk(IDX_ACT_START, 16'h01FF);
        rdchk(IDX_ACT_PER_FRAME, 16'h0005);
        rdchk(IDX_ACT_STARTUP, 16'h0001);
        cfg(16'h0001, 16'h000B, 16'h01FF, 16'h0005, 16'h0001, 16'h0020, ERR_TOTAL);
        chk(a_tot, 16'h000A);
        chk(param_error, 1'b1);
        wr(IDX_STATUS, 16'h0001);
        @(posedge clock);
        chk(param_error, 1'b0);
        rdchk(IDX_STATUS, 16'h0002);
        rdchk(IDX_ERROR, ERR_TOTAL);
        wr(IDX_STATUS, 16'h0002);
        rdchk(IDX_STATUS, 16'h0000);
        cfg(16'h0001, 16'h000A, 16'h0200, 16'h0005, 16'h0001, 16'h0020, ERR_START);
        chk(a_st, 16'h01FF);
        cfg(16'h0001, 16'h000A, 16'h0000, 16'h0006, 16'h0001, 16'h0020, ERR_PER_FRAME);
        chk(a_pf, 16'h0005);
        cfg(16'h0001, 16'h0002, 16'h0000, 16'h0003, 16'h0001, 16'h0020, ERR_COMBO);
        chk(a_tot, 16'h000A);
        cfg(16'h0001, 16'h0002, 16'h0000, 16'h0002, 16'h0002, 16'h0020, ERR_STARTUP);
        chk(a_su, 16'h0001);
        chk(a_tot, 16'h0002);
        cfg(16'h0001, 16'h0002, 16'h0000, 16'h0002, 16'h0000, 16'h0021, ERR_DCHECK);
        chk(a_dc, 16'h0020);
        chk(a_su, 16'h0000);
        cfg(16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, ERR_COMBO);
        cfg(16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, ERR_USE);
        chk(a_use, USE_ON);
        cfg(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, ERR_NONE);
        chk(a_use, USE_OFF);
        for (k = 16'h0001; k <= MAX_TOTAL; k++) begin
            cfg(USE_ON, k, k, (k > 16'h0005) ? 16'h0005 : k, 16'h0000, 16'h0000, ERR_NONE);
            chk(a_pf, (k > 16'h0005) ? 16'h0005 : k);
        end
        foreach (dcv[j]) begin
            cfg(USE_ON, 16'h0001, 16'h0000, 16'h0001, 16'h0000, dcv[j], ERR_NONE);
            chk(a_dc, dcv[j]);
        end
        // second reset mid-run, committed copies must clear
        arst_n <= 1'b0;
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        chk(a_tot, 16'h0000);
        rdchk(IDX_DCHECK, 16'h0000);
        print_verdict;
    end
endmodule
